// ### src/wdt_top.sv
`timescale 1ns/1ns
`include "wdt_consts.svh"

module wdt_top #(
   parameter int TB_HZ = `WDT_TB_HZ
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wdt_pkg::wdt_bus_req_t     bus_req,
   input  wire logic                 supply_monitor_irq,
   output logic [7:0]                bus_rdata,
   output logic                      sys_reset_req,
   output logic                      wdt_irq,
   output logic                      wdt_active
);

   logic                     tick;
   logic                     sel_ctrl;
   logic                     wr_ok;
   logic                     imm;
   logic                     timeout_hit;
   logic                     expire;
   logic                     reset_action;
   logic [16:0]              lim17;
   logic [`WDT_CNT_W-1:0]    lim;
   logic                     psm_edge;

   logic                     psm_meta_ff;
   logic                     psm_sync_ff;
   logic                     psm_prev_ff;

   wdt_pkg::wdt_ctrl_t       ctrl_ff;
   wdt_pkg::wdt_ctrl_t       nxt_ctrl;
   wdt_pkg::wdt_ctrl_t       wr_ctrl;
   logic                     unlock_ff;
   logic                     nxt_unlock;
   logic [`WDT_CNT_W-1:0]    cnt_ff;
   logic [`WDT_CNT_W-1:0]    nxt_cnt;
   wdt_pkg::wdt_state_t      state_ff;
   wdt_pkg::wdt_state_t      nxt_state;
   logic [7:0]               rdata_ff;
   logic [7:0]               nxt_rdata;
   logic                     rst_req_ff;
   logic                     nxt_rst_req;
   logic                     irq_ff;
   logic                     nxt_irq;
   logic                     active_ff;
   logic                     nxt_active;

   wdt_tick_div #(
      .TB_HZ   (TB_HZ)
   ) u_div (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tick)            // [RULE6]
   );

   // Supply monitor event crosses from its own logic as a level
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         psm_meta_ff <= 1'b0;
         psm_sync_ff <= 1'b0;
         psm_prev_ff <= 1'b0;
      end
      else
      begin
         psm_meta_ff <= supply_monitor_irq;
         psm_sync_ff <= psm_meta_ff;
         psm_prev_ff <= psm_sync_ff;
      end
   end

   assign psm_edge = psm_sync_ff & ~psm_prev_ff;

   // Decode and unlock window
   always_comb
   begin
      sel_ctrl = (bus_req.addr == `WDT_ADDR_CTRL);
      wr_ok    = bus_req.wr && sel_ctrl && unlock_ff;       // [RULE8]
      nxt_unlock = unlock_ff;
      if (bus_req.wr || bus_req.rd)
      begin
         // Any access closes the window; only a locked write can open it
         nxt_unlock = bus_req.wr && sel_ctrl && !unlock_ff &&
                      bus_req.wdata[`WDT_BIT_UNLOCK];       // [RULE8]
      end
   end

   // Timeout compare
   always_comb
   begin
      lim17 = (`WDT_BASE_TICKS << ctrl_ff.timeout_select[2:0]) - `WDT_ONE17;  // [RULE1]
      lim   = lim17[`WDT_CNT_W-1:0];
      imm   = ctrl_ff.kick_enable &&
              (ctrl_ff.timeout_select == `WDT_SEL_IMM);    // [RULE1]
      // Reserved codes never expire
      timeout_hit = ctrl_ff.kick_enable && tick && (cnt_ff == lim) &&
                    (ctrl_ff.timeout_select <= `WDT_SEL_MAX_TMO);   // [RULE4]
      expire       = (state_ff == wdt_pkg::WDT_ST_RUN) && (timeout_hit || imm);
      reset_action = expire && (imm || !ctrl_ff.irq_instead_of_reset);  // [RULE2]
   end

   // Control register
   always_comb
   begin
      wr_ctrl  = bus_req.wdata;
      nxt_ctrl = ctrl_ff;
      if (wr_ok)
      begin
         nxt_ctrl.timeout_select       = wr_ctrl.timeout_select;
         nxt_ctrl.irq_instead_of_reset = wr_ctrl.irq_instead_of_reset;
         nxt_ctrl.kick_enable          = wr_ctrl.kick_enable;       // [RULE7] [RULE9]
         if (!wr_ctrl.status)
         begin
            nxt_ctrl.status = 1'b0;
         end
      end
      if (reset_action || psm_edge)
      begin
         nxt_ctrl.kick_enable = 1'b0;                               // [RULE9]
      end
      // Timeout set beats a same-cycle software clear
      if (expire)
      begin
         nxt_ctrl.status = 1'b1;
      end
      nxt_ctrl.write_unlock = 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_ff   <= `WDT_CTRL_RST;                                // [RULE9]
         unlock_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff   <= nxt_ctrl;
         unlock_ff <= nxt_unlock;
      end
   end

   // Counter
   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (state_ff != wdt_pkg::WDT_ST_RUN || expire)
      begin
         nxt_cnt = `WDT_CNT_ZERO;
      end
      else if (wr_ok && wr_ctrl.kick_enable)
      begin
         nxt_cnt = `WDT_CNT_ZERO;                                   // [RULE7]
      end
      else if (tick)
      begin
         nxt_cnt = cnt_ff + `WDT_CNT_ONE;                           // [RULE6]
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cnt_ff <= `WDT_CNT_ZERO;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   // Sequencer
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         wdt_pkg::WDT_ST_OFF:
         begin
            if (ctrl_ff.kick_enable)
            begin
               nxt_state = wdt_pkg::WDT_ST_RUN;
            end
         end
         wdt_pkg::WDT_ST_RUN:
         begin
            if (expire)
            begin
               nxt_state = wdt_pkg::WDT_ST_FIRE;
            end
            else if (!ctrl_ff.kick_enable)
            begin
               nxt_state = wdt_pkg::WDT_ST_OFF;
            end
         end
         wdt_pkg::WDT_ST_FIRE:
         begin
            // Interrupt mode keeps running as a periodic timer
            if (ctrl_ff.kick_enable)
            begin
               nxt_state = wdt_pkg::WDT_ST_RUN;                     // [RULE3]
            end
            else
            begin
               nxt_state = wdt_pkg::WDT_ST_OFF;
            end
         end
         default:
         begin
            nxt_state = wdt_pkg::WDT_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_ff <= wdt_pkg::WDT_ST_OFF;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // Outputs and read data
   always_comb
   begin
      nxt_rst_req = reset_action;                                   // [RULE1] [RULE2]
      nxt_irq     = expire && !reset_action;                        // [RULE2] [RULE3]
      nxt_active  = (nxt_state != wdt_pkg::WDT_ST_OFF);
      nxt_rdata   = 8'h00;
      if (bus_req.rd && sel_ctrl)
      begin
         nxt_rdata = {ctrl_ff[7:1], unlock_ff};
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rst_req_ff <= 1'b0;
         irq_ff     <= 1'b0;
         active_ff  <= 1'b0;
         rdata_ff   <= 8'h00;
      end
      else
      begin
         rst_req_ff <= nxt_rst_req;
         irq_ff     <= nxt_irq;
         active_ff  <= nxt_active;
         rdata_ff   <= nxt_rdata;
      end
   end

   assign sys_reset_req = rst_req_ff;
   assign wdt_irq       = irq_ff;
   assign wdt_active    = active_ff;
   assign bus_rdata     = rdata_ff;

   AST_IMM_RESET: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE1]
      (state_ff == wdt_pkg::WDT_ST_RUN && ctrl_ff.kick_enable &&
       ctrl_ff.timeout_select == `WDT_SEL_IMM) |=> sys_reset_req && !wdt_irq)
      else $error("immediate code did not reset");

   AST_CODE0_PERIOD: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE1]
      (state_ff == wdt_pkg::WDT_ST_RUN && ctrl_ff.kick_enable && tick &&
       ctrl_ff.timeout_select == 4'h0 && cnt_ff == 16'h01FF) |=> (sys_reset_req || wdt_irq))
      else $error("code zero did not expire at 512 ticks");

   AST_RESET_MODE: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE2]
      (timeout_hit && state_ff == wdt_pkg::WDT_ST_RUN && !ctrl_ff.irq_instead_of_reset)
      |=> sys_reset_req && !wdt_irq ##1 !sys_reset_req)
      else $error("reset mode expiry wrong");

   AST_IRQ_MODE: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE2]
      (timeout_hit && state_ff == wdt_pkg::WDT_ST_RUN && ctrl_ff.irq_instead_of_reset)
      |=> wdt_irq && !sys_reset_req && ctrl_ff.status)
      else $error("interrupt mode expiry wrong");

   AST_PERIODIC: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE3]
      (wdt_irq && ctrl_ff.kick_enable) |=> state_ff == wdt_pkg::WDT_ST_RUN &&
       cnt_ff == `WDT_CNT_ZERO)
      else $error("timer did not restart after interrupt");

   AST_NO_EARLY: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE4]
      (state_ff == wdt_pkg::WDT_ST_RUN && tick &&
       ctrl_ff.timeout_select <= `WDT_SEL_MAX_TMO && cnt_ff < lim) |=> !wdt_irq && !sys_reset_req)
      else $error("expiry before interval");

   AST_HOLD: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE6]
      (state_ff == wdt_pkg::WDT_ST_RUN && !tick && !expire && !wr_ok) |=> $stable(cnt_ff))
      else $error("counter moved without tick");

   AST_KICK_CLR: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE7]
      (wr_ok && bus_req.wdata[`WDT_BIT_KICK] && !reset_action && !psm_edge)
      |=> cnt_ff == `WDT_CNT_ZERO && ctrl_ff.kick_enable)
      else $error("kick did not clear counter");

   AST_LOCKED: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE8]
      (bus_req.wr && !unlock_ff) |=> $stable(ctrl_ff.timeout_select) &&
       $stable(ctrl_ff.irq_instead_of_reset))
      else $error("locked write changed control");

   AST_SUPPLY: assert property (@(posedge ref_clk) disable iff (rst)   // [RULE9]
      psm_edge |=> !ctrl_ff.kick_enable)
      else $error("supply event left kick set");

endmodule

// ### src/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
// Behaviour
// RULE1: Timeout is 2^code times 512 ticks; 8 immediate
// RULE2: Expiry gives interrupt when requested, else reset; code 8 always resets, even with interrupt requested
// RULE3: Interrupt mode makes a periodic general timer
// RULE4: Prescale sets the interval between interrupts
// RULE5: Software avoids reserved prescale codes above eight
// RULE6: Sixteen bit counter on 32.768 kHz timebase
// RULE7: Kick within each period enables, clears counter
// RULE8: Control write only right after unlock access
// RULE9: Kick cleared by zero, reset, hardware, supply

// Register map
`define WDT_ADDR_W        8
`define WDT_ADDR_CTRL     8'h00
`define WDT_CTRL_RST      8'h10

// Control field positions
`define WDT_BIT_UNLOCK    0
`define WDT_BIT_KICK      1
`define WDT_BIT_STATUS    2
`define WDT_BIT_IRQ       3
`define WDT_SEL_LSB       4
`define WDT_SEL_MSB       7

// Prescale codes
`define WDT_SEL_MAX_TMO   4'h7
`define WDT_SEL_IMM       4'h8

// Timing
`define WDT_CLK_HZ        28'h5F5_E100
`define WDT_TB_HZ         32'h0000_8000
`define WDT_ACC_W         28
`define WDT_CNT_W         16
`define WDT_BASE_TICKS    17'h0_0200
`define WDT_ONE17         17'h0_0001
`define WDT_CNT_ZERO      16'h0000
`define WDT_CNT_ONE       16'h0001
`endif

// ### src/wdt_pkg.sv
package wdt_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } wdt_bus_req_t;

   typedef struct packed {
      logic [3:0] timeout_select;
      logic       irq_instead_of_reset;
      logic       status;
      logic       kick_enable;
      logic       write_unlock;
   } wdt_ctrl_t;

   typedef enum logic [2:0] {
      WDT_ST_OFF  = 3'b001,
      WDT_ST_RUN  = 3'b010,
      WDT_ST_FIRE = 3'b100
   } wdt_state_t;

endpackage

// ### src/wdt_tick_div.sv
`timescale 1ns/1ns
`include "wdt_consts.svh"

// Fractional divider: no drift against the core clock, jitter one cycle
module wdt_tick_div #(
   parameter int TB_HZ = `WDT_TB_HZ
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   output logic      tick
);
   localparam logic [`WDT_ACC_W-1:0] INC = `WDT_ACC_W'(TB_HZ);

   logic [`WDT_ACC_W-1:0] acc_ff;
   logic [`WDT_ACC_W-1:0] nxt_acc;
   logic [`WDT_ACC_W:0]   sum;
   logic                  tick_ff;
   logic                  nxt_tick;

   always_comb
   begin
      sum      = {1'b0, acc_ff} + {1'b0, INC};
      nxt_tick = (sum >= {1'b0, `WDT_CLK_HZ});
      if (nxt_tick)
      begin
         nxt_acc = sum[`WDT_ACC_W-1:0] - `WDT_CLK_HZ;
      end
      else
      begin
         nxt_acc = sum[`WDT_ACC_W-1:0];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         acc_ff  <= '0;
         tick_ff <= 1'b0;
      end
      else
      begin
         acc_ff  <= nxt_acc;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ns

module testbench;
   // Fast timebase: two core cycles per tick keeps every timeout short
   localparam int TB_HZ = 50_000_000;
   localparam int CPT   = 100_000_000 / TB_HZ;

   logic                  ref_clk            = 1'h0;
   logic                  rst                = 1'h1;
   wdt_pkg::wdt_bus_req_t bus_req            = '0;
   logic                  supply_monitor_irq = 1'h0;
   logic [7:0]            bus_rdata;
   logic                  sys_reset_req;
   logic                  wdt_irq;
   logic                  wdt_active;
   int                    n_mismatch         = 0;
   int                    num_checks         = 0;
   logic [3:0]            row_code [5]       = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h1};
   logic                  row_irq  [5]       = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0};

   always #5 ref_clk = ~ref_clk;

   wdt_top #(
      .TB_HZ (TB_HZ)
   ) dut (
      .ref_clk            (ref_clk),
      .rst                (rst),
      .bus_req            (bus_req),
      .supply_monitor_irq (supply_monitor_irq),
      .bus_rdata          (bus_rdata),
      .sys_reset_req      (sys_reset_req),
      .wdt_irq            (wdt_irq),
      .wdt_active         (wdt_active)
   );

   task automatic complete_run();
      if (n_mismatch == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic chk1(input string nm, input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %b got %b", nm, exp, got);
      end
   endtask

   task automatic chk_cnt(input string nm, input int exp, input int got, input int tol);
      num_checks++;
      if (got < exp - tol || got > exp + tol)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %0d got %0d", nm, exp, got);
      end
   endtask

   // Entered at a rising edge; one idle cycle after each strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_req <= '{a, d, 1'h1, 1'h0};
      @(posedge ref_clk);
      bus_req <= '0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus_req <= '{a, 8'h00, 1'h0, 1'h1};
      @(posedge ref_clk);
      bus_req <= '0;
      #1 d = bus_rdata;
      @(posedge ref_clk);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] exp);
      logic [7:0] d;
      rd(8'h00, d);
      chk8(nm, exp, d);
   endtask

   task automatic cfg(input logic [7:0] d);
      wr(8'h00, 8'h01);
      wr(8'h00, d);
   endtask

   // Kind: 0 none, 1 interrupt, 2 system reset
   task automatic wait_pulse(input int max, output int kind, output int n);
      kind = 0;
      for (n = 0; n < max && kind == 0; n++)
      begin
         @(posedge ref_clk);
         #1;
         if (wdt_irq === 1'h1)
            kind = 1;
         else if (sys_reset_req === 1'h1)
            kind = 2;
      end
      @(posedge ref_clk);
   endtask

   task automatic chk_quiet();
      #1;
      chk8("rdata_rst", 8'h00, bus_rdata);
      chk1("sysrst_rst", 1'h0, sys_reset_req);
      chk1("irq_rst", 1'h0, wdt_irq);
      chk1("active_rst", 1'h0, wdt_active);
   endtask

   initial
   begin
      #1_000_000;
      n_mismatch++;
      complete_run();
   end

   initial
   begin
      logic [7:0] d;
      int         kind;
      int         n;
      int         exp;
      repeat (4) @(posedge ref_clk);
      rst <= 1'h0;
      chk_quiet();
      @(posedge ref_clk);
      rdchk("ctrl_rst", 8'h10);
      for (int i = 0; i < 5; i++)
      begin
         exp = (512 << row_code[i]) * CPT;
         cfg({row_code[i], row_irq[i], 3'h2});
         wait_pulse(exp + 50, kind, n);
         chk_cnt("kind", row_irq[i] ? 1 : 2, kind, 0);
         chk_cnt("first", exp, n, 6);
         if (row_irq[i])
         begin
            wait_pulse(exp + 50, kind, n);
            chk_cnt("again", 1, kind, 0);
            chk_cnt("period", exp, n, 3);
         end
         rdchk("status", {row_code[i], row_irq[i], 1'h1, row_irq[i], 1'h0});
         #1;
         chk1("active", row_irq[i], wdt_active);
         @(posedge ref_clk);
         cfg({row_code[i], 4'h0});
      end
      wr(8'h00, 8'h32);
      rdchk("locked", 8'h10);
      wr(8'h00, 8'h01);
      rdchk("window", 8'h11);
      wr(8'h00, 8'h32);
      rdchk("closed", 8'h10);
      wr(8'h00, 8'h01);
      wr(8'h05, 8'h32);
      wr(8'h00, 8'h32);
      rdchk("unmapped_wr", 8'h10);
      rd(8'h05, d);
      chk8("unmapped_rd", 8'h00, d);
      // Refresh well inside the shortest period, then stop refreshing
      repeat (3)
      begin
         cfg(8'h02);
         wait_pulse(700, kind, n);
         chk_cnt("kicked", 0, kind, 0);
      end
      wait_pulse(1100, kind, n);
      chk_cnt("starved", 2, kind, 0);
      rdchk("starved_ctrl", 8'h04);
      cfg(8'h8A);
      wait_pulse(10, kind, n);
      chk_cnt("immediate", 2, kind, 0);
      rdchk("imm_ctrl", 8'h8C);
      // Reserved code on purpose: expected never to expire
      cfg(8'h9A);
      wait_pulse(5000, kind, n);
      chk_cnt("reserved", 0, kind, 0);
      #1;
      chk1("reserved_active", 1'h1, wdt_active);
      @(posedge ref_clk);
      // Synchronizer delay of a few cycles before the clear lands
      supply_monitor_irq <= 1'h1;
      repeat (8) @(posedge ref_clk);
      rdchk("supply", 8'h98);
      supply_monitor_irq <= 1'h0;
      cfg(8'h0A);
      repeat (100) @(posedge ref_clk);
      rst <= 1'h1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'h0;
      chk_quiet();
      @(posedge ref_clk);
      rdchk("ctrl_rerst", 8'h10);
      complete_run();
   end
endmodule
